// File: hw/flm_consts.vh
// Constants for the force limit monitor core
`ifndef FLM_CONSTS_VH
`define FLM_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define FLM_REG_CTRL     6'h00
`define FLM_REG_OFFSET   6'h01
`define FLM_REG_GAIN     6'h02
`define FLM_REG_STATUS   6'h03
`define FLM_REG_RAW      6'h04
`define FLM_REG_OUTPUT   6'h05

// ****************************************
// Field positions
// ****************************************
`define FLM_CTRL_VARIANT 0
`define FLM_ST_OVERLOAD  0
`define FLM_ST_OVERFLOW  1
`define FLM_ST_UNDERFLOW 2
`define FLM_ST_BUSY      3
`define FLM_ST_VARIANT   4

// ****************************************
// Reset values and limits
// ****************************************
`define FLM_OFFSET_RST   16'h0000
`define FLM_OFFSET_MAX   16'h3e80
`define FLM_OFFSET_MIN   16'hc180
`define FLM_GAIN_ONE     1000
`define FLM_GAIN_MIN     16'h0064
`define FLM_GAIN_MAX     16'h4e20
`define FLM_GAIN_RST     16'h03e8

// ****************************************
// Scaling
// ****************************************
`define FLM_FS_DIGITS    11890
`define FLM_NOM_MV       9
`define FLM_OVL_MV       12
`define FLM_OVL_TRIP     ((`FLM_OVL_MV * `FLM_FS_DIGITS) / `FLM_NOM_MV)
`define FLM_OVL_HYST     ((`FLM_FS_DIGITS / 2) / `FLM_NOM_MV)
`define FLM_OVL_REL      (`FLM_OVL_TRIP - `FLM_OVL_HYST)
`define FLM_DAC_FS       2000
`define FLM_OUT_HYST     10
`define FLM_OVF_TRIP     (`FLM_DAC_FS + `FLM_OUT_HYST)
`define FLM_OVF_REL      (`FLM_DAC_FS - `FLM_OUT_HYST)
`define FLM_UDF_TRIP     (`FLM_OUT_HYST)
`define FLM_DIVISOR      ((`FLM_GAIN_ONE * `FLM_FS_DIGITS) / `FLM_DAC_FS)

`endif

// File: hw/flm_core.v
// Force limit monitor: calibration, output value, limit flags, Wishbone registers
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "flm_consts.vh"

module flm_core (
  input  wire        clk,          // System clock, 50 MHz
  input  wire        reset,        // Synchronous reset, active high
  input  wire        wb_cyc_i,     // Wishbone cycle
  input  wire        wb_stb_i,     // Wishbone strobe
  input  wire        wb_we_i,      // Wishbone write enable
  input  wire [7:0]  wb_adr_i,     // Wishbone byte address
  input  wire [3:0]  wb_sel_i,     // Wishbone byte selects
  input  wire [31:0] wb_dat_i,     // Wishbone write data
  output reg  [31:0] wb_dat_o,     // Wishbone read data
  output reg         wb_ack_o,     // Wishbone acknowledge
  input  wire        adc_valid,    // Raw sample offered
  input  wire [15:0] adc_sample,   // Raw signed converter sample
  output wire        adc_ready,    // Core idle, sample taken
  output reg  [10:0] dac_value,    // Output converter value, 0..2000
  output reg         dac_valid,    // Pulse: new output value
  output reg         overload,     // Raw input overload flag
  output reg         overflow,     // Output overflow flag
  output reg         underflow     // Output underflow flag
);

  // ****************************************
  // State machine
  // ****************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_MUL  = 4'h2;
  localparam [3:0] ST_DIV  = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  localparam integer OVF_TRIP = `FLM_OVF_TRIP;
  localparam integer OVF_REL  = `FLM_OVF_REL;
  localparam integer UDF_TRIP = `FLM_UDF_TRIP;
  localparam integer DAC_FS   = `FLM_DAC_FS;
  localparam integer OVL_TRIP = `FLM_OVL_TRIP;
  localparam integer OVL_REL  = `FLM_OVL_REL;
  localparam integer DIV_FULL = `FLM_DIVISOR;
  localparam [15:0]  DIVISOR  = DIV_FULL[15:0];

  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg         variant_reg;
  reg  [15:0] offset_reg;
  reg  [15:0] gain_reg;
  reg  [15:0] raw_reg;
  reg  [32:0] prod_reg;
  reg         neg_reg;
  reg  signed [19:0] comp_reg;
  reg         div_start;

  wire        div_done;
  wire [31:0] div_quot;
  wire        take;
  wire [5:0]  reg_idx;
  wire        wr_en;
  wire        rd_en;
  wire signed [16:0] corrected;
  wire signed [32:0] product;
  wire [15:0] raw_mag;
  wire signed [19:0] comp_val;

  // ****************************************
  // Helper functions
  // ****************************************
  function [15:0] mag16;
    input [15:0] v;
    begin
      mag16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] dat;
    input [1:0]  sel;
    begin
      merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  function [15:0] clamp_offset;
    input [15:0] v;
    begin
      if ($signed(v) > $signed(`FLM_OFFSET_MAX))
        clamp_offset = `FLM_OFFSET_MAX;
      else if ($signed(v) < $signed(`FLM_OFFSET_MIN))
        clamp_offset = `FLM_OFFSET_MIN;
      else
        clamp_offset = v;
    end
  endfunction

  function [15:0] clamp_gain;
    input [15:0] v;
    begin
      if (v < `FLM_GAIN_MIN)
        clamp_gain = `FLM_GAIN_MIN;
      else if (v > `FLM_GAIN_MAX)
        clamp_gain = `FLM_GAIN_MAX;
      else
        clamp_gain = v;
    end
  endfunction

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign reg_idx = wb_adr_i[7:2];
  assign wr_en   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign rd_en   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  always @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      case (reg_idx)
        `FLM_REG_CTRL:   wb_dat_o <= {31'h0000_0000, variant_reg};
        `FLM_REG_OFFSET: wb_dat_o <= {16'h0000, offset_reg};
        `FLM_REG_GAIN:   wb_dat_o <= {16'h0000, gain_reg};
        `FLM_REG_STATUS: wb_dat_o <= {27'h000_0000, variant_reg, ~state_reg[0],
                                      underflow, overflow, overload};
        `FLM_REG_RAW:    wb_dat_o <= {16'h0000, raw_reg};
        `FLM_REG_OUTPUT: wb_dat_o <= {12'h000, comp_reg};
        default:         wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Writes land one edge after ack rises, at the edge that samples ack high
  always @(posedge clk) begin
    if (reset) begin
      variant_reg <= 1'b0;
      offset_reg  <= `FLM_OFFSET_RST;
      gain_reg    <= `FLM_GAIN_RST;
    end else if (wr_en) begin
      case (reg_idx)
        `FLM_REG_CTRL: begin
          if (wb_sel_i[0])
            variant_reg <= wb_dat_i[`FLM_CTRL_VARIANT];
        end
        `FLM_REG_OFFSET: begin
          offset_reg <= clamp_offset(merge16(offset_reg, wb_dat_i[15:0],
                                             wb_sel_i[1:0]));
        end
        `FLM_REG_GAIN: begin
          gain_reg <= clamp_gain(merge16(gain_reg, wb_dat_i[15:0],
                                         wb_sel_i[1:0]));
        end
        default: begin
          variant_reg <= variant_reg;
        end
      endcase
    end
  end

  // ****************************************
  // Sample intake and overload test
  // ****************************************
  assign adc_ready = state_reg[0];
  assign take      = adc_valid & state_reg[0];
  assign raw_mag   = mag16(adc_sample);

  always @(posedge clk) begin
    if (reset) begin
      raw_reg  <= 16'h0000;
      overload <= 1'b0;
    end else if (take) begin
      raw_reg <= adc_sample;
      if (raw_mag >= OVL_TRIP)
        overload <= 1'b1;
      else if (raw_mag <= OVL_REL)
        overload <= 1'b0;
    end
  end

  // ****************************************
  // Calibration arithmetic
  // ****************************************
  // 16-bit input carries the 33 percent overload with margin
  assign corrected = $signed({raw_reg[15], raw_reg}) -
                     $signed({offset_reg[15], offset_reg});
  assign product   = corrected * $signed({1'b0, gain_reg});

  // Full scale digits map to full scale output
  assign comp_val  = neg_reg ? -$signed({2'b00, div_quot[17:0]})
                             : $signed({2'b00, div_quot[17:0]});

  always @(posedge clk) begin
    if (reset) begin
      prod_reg  <= 33'h0_0000_0000;
      neg_reg   <= 1'b0;
      div_start <= 1'b0;
    end else begin
      div_start <= 1'b0;
      if (state_reg[1]) begin
        prod_reg  <= product[32] ? (~product + 33'h0_0000_0001) : product;
        neg_reg   <= product[32];
        div_start <= 1'b1;
      end
    end
  end

  flm_udiv u_div (
    .clk      (clk),
    .reset    (reset),
    .start    (div_start),
    .dividend (prod_reg[31:0]),
    .divisor  (DIVISOR),
    .done     (div_done),
    .quotient (div_quot)
  );

  always @* begin
    case (state_reg)
      ST_IDLE: state_next = take ? ST_MUL : ST_IDLE;
      ST_MUL:  state_next = ST_DIV;
      ST_DIV:  state_next = div_done ? ST_DONE : ST_DIV;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (reset)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // ****************************************
  // Output value and overflow/underflow test
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      comp_reg  <= 20'h0_0000;
      dac_value <= 11'h000;
      dac_valid <= 1'b0;
      overflow  <= 1'b0;
      underflow <= 1'b0;
    end else begin
      dac_valid <= 1'b0;
      if (state_reg[2] && div_done) begin
        comp_reg  <= comp_val;
        dac_valid <= 1'b1;
        if (comp_val < 20'sd0)
          dac_value <= 11'h000;
        else if (comp_val > DAC_FS)
          dac_value <= DAC_FS[10:0];
        else
          dac_value <= comp_val[10:0];
        if (comp_val >= OVF_TRIP)
          overflow <= 1'b1;
        else if (comp_val > UDF_TRIP && comp_val < OVF_REL)
          overflow <= 1'b0;
        if (comp_val <= UDF_TRIP)
          underflow <= 1'b1;
        else if (comp_val < OVF_REL)
          underflow <= 1'b0;
      end
    end
  end

endmodule // flm_core

`default_nettype wire

// File: hw/flm_udiv.v
// Sequential unsigned restoring divider
`timescale 1ns/1ns
`default_nettype none

module flm_udiv (
  input  wire        clk,       // System clock
  input  wire        reset,     // Synchronous reset, active high
  input  wire        start,     // Pulse: load operands
  input  wire [31:0] dividend,  // Numerator
  input  wire [15:0] divisor,   // Denominator, nonzero
  output reg         done,      // Pulse: quotient valid
  output reg  [31:0] quotient   // Result
);

  reg  [31:0] num_reg;
  reg  [16:0] rem_reg;
  reg  [15:0] den_reg;
  reg  [5:0]  cnt_reg;
  reg         run_reg;
  wire [16:0] trial;
  wire [16:0] diff;

  assign trial = {rem_reg[15:0], num_reg[31]};
  assign diff  = trial - {1'b0, den_reg};

  always @(posedge clk) begin
    if (reset) begin
      num_reg  <= 32'h0000_0000;
      rem_reg  <= 17'h0_0000;
      den_reg  <= 16'h0000;
      cnt_reg  <= 6'h00;
      run_reg  <= 1'b0;
      done     <= 1'b0;
      quotient <= 32'h0000_0000;
    end else begin
      done <= 1'b0;
      if (start) begin
        num_reg <= dividend;
        den_reg <= divisor;
        rem_reg <= 17'h0_0000;
        cnt_reg <= 6'h20;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (!diff[16]) begin
          rem_reg <= diff;
          num_reg <= {num_reg[30:0], 1'b1};
        end else begin
          rem_reg <= trial;
          num_reg <= {num_reg[30:0], 1'b0};
        end
        cnt_reg <= cnt_reg - 6'h01;
        if (cnt_reg == 6'h01) begin
          run_reg  <= 1'b0;
          done     <= 1'b1;
          quotient <= {num_reg[30:0], ~diff[16]};
        end
      end
    end
  end

endmodule // flm_udiv

`default_nettype wire

// File: tb/flm_core_bench.sv
// Self-checking bench for the force limit monitor core
`timescale 1ns/1ns
`default_nettype none

module flm_core_bench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        wen = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic        go = 1'b0;
  logic [3:0]  lag = 4'h0;
  logic [15:0] value = 16'h0000;
  logic [31:0] rdat, q;
  logic        ack, adc_valid, adc_ready, dac_valid, overload, overflow, underflow;
  logic [15:0] adc_sample;
  logic [10:0] dac_value;
  logic        m_ovl = 1'b0, m_ovf = 1'b0, m_udf = 1'b0;
  int          mismatches = 0, checks_done = 0, cycles = 0, m_off = 0, m_gain = 1000, g = 0;
  int          raws [18] = '{5945, 11949, 11950, 11840, 11830, 60, 65, 66, -100,
                             15852, 15853, 15200, 15194, 15193, -15852, -15853, -15194, -15193};
  logic [63:0] ctab [5] = '{{8'h08, 4'hf, 20'h07530, 32'h00004e20},
                            {8'h08, 4'hf, 20'h00032, 32'h00000064},
                            {8'h08, 4'h1, 20'h000ff, 32'h000000ff},
                            {8'h04, 4'h3, 20'h0b1e0, 32'h0000c180},
                            {8'h04, 4'h3, 20'h04e20, 32'h00003e80}};

  flm_core dut (
    .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .adc_valid(adc_valid), .adc_sample(adc_sample), .adc_ready(adc_ready),
    .dac_value(dac_value), .dac_valid(dac_valid), .overload(overload),
    .overflow(overflow), .underflow(underflow));

  flm_sensor_model sensor (
    .clk(clk), .reset(reset), .go(go), .lag(lag), .value(value),
    .adc_ready(adc_ready), .adc_valid(adc_valid), .adc_sample(adc_sample));

  always #10 clk = ~clk;

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                         input logic [3:0] s, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= we;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    wen <= 1'b0;
  endtask

  // One sample through the core, flags and output checked against the model
  task automatic send(input int raw, input int l);
    int o;
    int mag;
    o = ((raw - m_off) * m_gain) / 5945;
    mag = raw < 0 ? -raw : raw;
    if (mag >= 15853) m_ovl = 1'b1;
    else if (mag <= 15193) m_ovl = 1'b0;
    if (o >= 2010) m_ovf = 1'b1;
    else if (o > 10 && o < 1990) m_ovf = 1'b0;
    if (o <= 10) m_udf = 1'b1;
    else if (o < 1990) m_udf = 1'b0;
    value <= raw[15:0];
    lag <= l[3:0];
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (dac_valid !== 1'b1) @(posedge clk);
    chk({29'h0, underflow, overflow, overload}, {29'h0, m_udf, m_ovf, m_ovl});
    chk({21'h0, dac_value}, o < 0 ? 0 : (o > 2000 ? 2000 : o));
    wb_xfer(8'h14, 1'b0, 32'h0, 4'hf, q);
    chk(q, {12'h0, o[19:0]});
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    wb_xfer(8'h04, 1'b0, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    wb_xfer(8'h08, 1'b0, 32'h0, 4'hf, q);
    chk(q, 32'h3e8);
    wb_xfer(8'h3c, 1'b1, 32'hffff, 4'hf, q);
    wb_xfer(8'h3c, 1'b0, 32'h0, 4'hf, q);
    chk(q, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wb_xfer(ctab[i][63:56], 1'b1, {12'h0, ctab[i][51:32]}, ctab[i][55:52], q);
      wb_xfer(ctab[i][63:56], 1'b0, 32'h0, 4'hf, q);
      chk(q, ctab[i][31:0]);
    end
    // Offset zeroed unloaded before gain is set
    wb_xfer(8'h04, 1'b1, 32'h0, 4'hf, q);
    wb_xfer(8'h08, 1'b1, 32'h3e8, 4'hf, q);
    for (int i = 0; i < 18; i++) send(raws[i], (i % 3) * 5);
    wb_xfer(8'h04, 1'b1, 32'h64, 4'hf, q);
    m_off = 100;
    wb_xfer(8'h08, 1'b1, 32'h7d0, 4'hf, q);
    m_gain = 2000;
    send(3072, 0);
    send(-3000, 4);
    // Controller gain: two 500 N sensors, 500 N applied, 4980 counts measured
    g = int'(longint'(500) * 11890 * 1000 / (longint'(2 * 500) * 4980));
    wb_xfer(8'h08, 1'b1, g, 4'hf, q);
    m_gain = g;
    send(4980 + m_off, 0);
    chk({21'h0, dac_value}, 32'h0000_03e7);
    wb_xfer(8'h00, 1'b1, 32'h1, 4'h1, q);
    wb_xfer(8'h00, 1'b0, 32'h0, 4'hf, q);
    chk(q, 32'h1);
    send(15853, 0);
    wb_xfer(8'h0c, 1'b0, 32'h0, 4'hf, q);
    chk(q, {27'h1, 1'b0, m_udf, m_ovf, m_ovl});
    wb_xfer(8'h10, 1'b1, 32'h0, 4'hf, q);
    wb_xfer(8'h10, 1'b0, 32'h0, 4'hf, q);
    chk(q, 32'h3ded);
    complete_run;
  end
endmodule // flm_core_bench

`default_nettype wire

// File: tb/flm_core_chk.sv
// Port assertions for the force limit monitor core
`timescale 1ns/1ns
`default_nettype none

module flm_core_chk (
  input wire logic        clk,         // Clock
  input wire logic        reset,       // Reset
  input wire logic        wb_cyc_i,    // Cycle
  input wire logic        wb_stb_i,    // Strobe
  input wire logic        wb_ack_o,    // Ack
  input wire logic        adc_valid,   // Offer
  input wire logic [15:0] adc_sample,  // Raw
  input wire logic        adc_ready,   // Idle
  input wire logic [10:0] dac_value,   // Output
  input wire logic        dac_valid,   // New output
  input wire logic        overload,    // Flag
  input wire logic        overflow,    // Flag
  input wire logic        underflow    // Flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wire logic take = adc_valid && adc_ready;
  wire logic trip = $signed(adc_sample) >= 16'sh3ded || $signed(adc_sample) <= -16'sh3ded;
  wire logic calm = $signed(adc_sample) <= 16'sh3b59 && $signed(adc_sample) >= -16'sh3b59;

  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ovl_trip: assert property (take && trip |=> overload)
    else $error("overload not set at threshold");
  a_ovl_release: assert property (take && calm |=> !overload)
    else $error("overload not released");
  a_ovl_hold: assert property (take && !trip && !calm |=> $stable(overload))
    else $error("overload moved inside hysteresis");
  a_ovl_quiet: assert property (!take |=> $stable(overload))
    else $error("overload moved without a sample");
  a_result_time: assert property (take |-> ##36 dac_valid)
    else $error("output value late");
  a_busy_gap: assert property (take |=> !adc_ready [*8])
    else $error("ready during computation");
  a_flags_move: assert property ($changed({overflow, underflow}) |-> dac_valid)
    else $error("limit flags moved without output");
  a_ovf_level: assert property ($rose(overflow) |-> dac_value == 11'h7d0)
    else $error("overflow with low output");
  a_udf_level: assert property ($rose(underflow) |-> dac_value <= 11'h00a)
    else $error("underflow with high output");
  a_dac_span: assert property (dac_value <= 11'h7d0)
    else $error("output beyond full scale");

  cover property (take && trip);
  cover property (dac_valid && overflow);
  cover property (dac_valid && underflow);
endmodule // flm_core_chk

bind flm_core flm_core_chk u_chk (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .adc_valid(adc_valid), .adc_sample(adc_sample), .adc_ready(adc_ready),
  .dac_value(dac_value), .dac_valid(dac_valid), .overload(overload),
  .overflow(overflow), .underflow(underflow));

`default_nettype wire

// File: tb/flm_sensor_model.sv
// Bridge sensor and converter model that offers raw samples to the core
`timescale 1ns/1ns
`default_nettype none

module flm_sensor_model (
  input  wire logic        clk,        // Clock
  input  wire logic        reset,      // Reset
  input  wire logic        go,         // Pulse: offer value
  input  wire logic [3:0]  lag,        // Cycles before offer
  input  wire logic [15:0] value,      // Raw count
  input  wire logic        adc_ready,  // Core idle
  output var  logic        adc_valid,  // Sample offered
  output var  logic [15:0] adc_sample  // Raw sample
);
  logic       armed;
  logic [3:0] wait_cnt;

  always @(posedge clk) begin
    if (reset) begin
      armed <= 1'b0;
      wait_cnt <= 4'h0;
      adc_valid <= 1'b0;
      adc_sample <= 16'h0000;
    end else if (adc_valid && adc_ready) begin
      adc_valid <= 1'b0;
      adc_sample <= ~adc_sample;
    end else if (go) begin
      armed <= 1'b1;
      wait_cnt <= lag;
    end else if (armed && wait_cnt == 4'h0) begin
      armed <= 1'b0;
      adc_valid <= 1'b1;
      adc_sample <= value;
    end else if (armed) begin
      wait_cnt <= wait_cnt - 4'h1;
    end
  end
endmodule // flm_sensor_model

`default_nettype wire
